// file: iss_pkg.sv
package iss_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS   = 8'hdc;
    localparam logic [7:0] IDX_OWN      = 8'hdd;
    localparam logic [7:0] IDX_DATA     = 8'hde;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hdf;
    localparam logic [7:0] IDX_IRQ_MASK = 8'he0;
    localparam logic [7:0] IDX_CTRL     = 8'he1;

    localparam logic [ADDR_W-1:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_OWN      = {2'h0, IDX_OWN, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DATA     = {2'h0, IDX_DATA, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = {2'h0, IDX_CTRL, 2'h0};

    // status register bit positions
    localparam int SB_FIRST = 7;
    localparam int SB_ADDR  = 6;
    localparam int SB_STOP  = 5;
    localparam int SB_RPS   = 4;
    localparam int SB_TXB   = 3;
    localparam int SB_RCB   = 2;
    localparam int SB_START = 1;
    localparam int SB_NACK  = 0;
    localparam int HOLD_LSB = 0;
    localparam int HOLD_W   = 4;

    // own address register
    localparam int OWN_EN_BIT = 7;
    localparam int OWN_ADDR_W = 7;

    // interrupt status / mask layout
    localparam int IRQ_W    = 6;
    localparam int IRQ_ADDR = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_RPS  = 2;
    localparam int IRQ_TXB  = 3;
    localparam int IRQ_RCB  = 4;
    localparam int IRQ_NACK = 5;

    // control register
    localparam int CTRL_NACK_CLR = 0;
    localparam int CTRL_XMT      = 1;

    // reset values
    localparam logic [7:0]       RST_BYTE = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ  = 6'h00;

    // timing
    localparam logic [4:0] HOLD_BASE = 5'h03;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_RX,
        S_ACK,
        S_ACKD,
        S_TX,
        S_MACK
    } iss_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } iss_pins_in_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } iss_pins_out_t;

endpackage

// file: iss_slave.sv
// Contract
// RULE1 - a 7-bit address matching the own address sets the match flag, cleared only by software.
// RULE2 - the match flag with its interrupt enable raises the interrupt.
// RULE3 - a STOP sets the stop flag until software clears it.
// RULE4 - a repeated START sets its flag until software clears it.
// RULE5 - the tx buffer flag sets when a byte can be taken and clears on a data write.
// RULE6 - the rx buffer flag sets when a byte lands in the data register and clears on its read.
// RULE7 - a read-only start indicator is set by a START and cleared by a STOP.
// RULE8 - in transmit a master NACK sets the nack flag.
// RULE9 - after a NACK no new byte is loaded and the old byte is resent until acknowledged.
// RULE10 - the nack flag clears on a new ACK or a software write.
// RULE11 - a four-bit hold field delays SDA after SCL by its value plus 3 cycles.
// RULE12 - software picks a hold value giving at least 300 ns of hold time.
// RULE13 - the own address register holds enable in bit 7, address in bits 6 to 0, and reads zero.
// RULE14 - a hardware set wins over a software clear in the same cycle.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module iss_slave
    import iss_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic [iss_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output var  logic                         s_axi_awready,
    input  wire logic [iss_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output var  logic                         s_axi_wready,
    output var  logic [1:0]                   s_axi_bresp,
    output var  logic                         s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [iss_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output var  logic                         s_axi_arready,
    output var  logic [iss_pkg::DATA_W-1:0]   s_axi_rdata,
    output var  logic [1:0]                   s_axi_rresp,
    output var  logic                         s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire iss_pkg::iss_pins_in_t        pins_in,
    output var  iss_pkg::iss_pins_out_t       pins_out,
    output var  logic                         irq
);
    import iss_pkg::*;

    function automatic logic upd(input logic cur, input logic set, input logic clr);
        upd = set | (cur & ~clr); // RULE14
    endfunction
    logic [2:0]  scl_sync_reg;
    logic [2:0]  sda_sync_reg;
    logic        scl_f_reg;
    logic        sda_f_reg;
    logic        scl_d_reg;
    logic        sda_d_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_f_reg    <= 1'b1;
            sda_f_reg    <= 1'b1;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], pins_in.scl};
            sda_sync_reg <= {sda_sync_reg[1:0], pins_in.sda};
            // a level counts only once stages two and three agree
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_f_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_f_reg <= sda_sync_reg[2];
            end
            scl_d_reg <= scl_f_reg;
            sda_d_reg <= sda_f_reg;
        end
    end

    wire scl_rise  = scl_f_reg & ~scl_d_reg;
    wire scl_fall  = ~scl_f_reg & scl_d_reg;
    wire scl_high  = scl_f_reg & scl_d_reg;
    wire start_det = sda_d_reg & ~sda_f_reg & scl_high;
    wire stop_det  = ~sda_d_reg & sda_f_reg & scl_high;
    iss_state_t          state_reg;
    logic [2:0]          bit_cnt_reg;
    logic [7:0]          rx_sh_reg;
    logic [7:0]          tx_sh_reg;
    logic                xmt_reg;
    logic                resend_reg;
    logic                pend_reg;
    logic [4:0]          hold_cnt_reg;
    logic                first_reg;
    logic                addr_flag_reg;
    logic                stop_flag_reg;
    logic                rps_flag_reg;
    logic                txb_reg;
    logic                rcb_reg;
    logic                start_reg;
    logic                nack_reg;
    logic [HOLD_W-1:0]   hold_reg;
    logic [OWN_ADDR_W-1:0] own_addr_reg;
    logic                slave_en_reg;
    logic [7:0]          tx_data_reg;
    logic [7:0]          rx_data_reg;
    logic [IRQ_W-1:0]    irq_stat_reg;
    logic [IRQ_W-1:0]    irq_mask_reg;
    wire [7:0] rx_in      = {rx_sh_reg[6:0], sda_f_reg};
    wire       bit_last   = scl_rise & (bit_cnt_reg == 3'h7);
    wire       addr_done  = (state_reg == S_ADDR) & bit_last;
    wire       addr_hit   = addr_done & slave_en_reg & (rx_in[7:1] == own_addr_reg); // RULE1
    wire       rx_done    = (state_reg == S_RX) & bit_last;
    wire       mack_rise  = (state_reg == S_MACK) & scl_rise;
    wire       got_nack   = mack_rise & sda_f_reg;
    wire       got_ack    = mack_rise & ~sda_f_reg;
    wire       load_point = scl_fall & (((state_reg == S_ACKD) & xmt_reg) | (state_reg == S_MACK));
    wire       tx_load    = load_point & ~resend_reg; // RULE9
    wire [7:0] tx_next    = tx_load ? tx_data_reg : tx_sh_reg;
    wire       rps_evt    = start_det & start_reg;
    wire [2:0] tx_idx     = 3'h6 - bit_cnt_reg;
    // 1 means pull sda low after the hold delay
    logic drv_next;
    always_comb begin
        case (state_reg)
            S_ACK:   drv_next = 1'b1;
            S_ACKD:  drv_next = xmt_reg & ~tx_next[7];
            S_TX:    drv_next = (bit_cnt_reg != 3'h7) & ~tx_sh_reg[tx_idx];
            S_MACK:  drv_next = ~resend_reg & ~tx_next[7];
            default: drv_next = 1'b0;
        endcase
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= S_IDLE;
            bit_cnt_reg <= 3'h0;
            rx_sh_reg   <= RST_BYTE;
            tx_sh_reg   <= RST_BYTE;
            xmt_reg     <= 1'b0;
            resend_reg  <= 1'b0;
        end else if (start_det) begin
            state_reg   <= S_ADDR;
            bit_cnt_reg <= 3'h0;
        end else if (stop_det) begin
            state_reg   <= S_IDLE;
        end else begin
            if (addr_hit) begin
                xmt_reg <= rx_in[0];
            end
            if (got_nack) begin
                resend_reg <= 1'b1; // RULE9
            end else if (got_ack) begin
                resend_reg <= 1'b0;
            end
            if (tx_load) begin
                tx_sh_reg <= tx_data_reg;
            end
            case (state_reg)
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        rx_sh_reg   <= rx_in;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    if (addr_done) begin
                        state_reg <= addr_hit ? S_ACK : S_IDLE;
                    end else if (rx_done) begin
                        state_reg <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        state_reg <= S_ACKD;
                    end
                end
                S_ACKD: begin
                    if (scl_fall) begin
                        state_reg   <= xmt_reg ? S_TX : S_RX;
                        bit_cnt_reg <= 3'h0;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == 3'h7) begin
                            state_reg <= S_MACK;
                        end
                    end
                end
                S_MACK: begin
                    // after a nack the master ends the frame; the byte stays for the next one
                    if (scl_fall) begin
                        state_reg   <= resend_reg ? S_IDLE : S_TX;
                        bit_cnt_reg <= 3'h0;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // sda changes hold+3 cycles after the filtered scl fall
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_reg     <= 1'b0;
            hold_cnt_reg <= 5'h00;
            pins_out     <= '{sda_o: 1'b0, sda_oe: 1'b0};
        end else if (start_det | stop_det) begin
            hold_cnt_reg    <= 5'h00;
            pins_out.sda_oe <= 1'b0;
        end else if (scl_fall) begin
            pend_reg     <= drv_next;
            hold_cnt_reg <= {1'b0, hold_reg} + HOLD_BASE; // RULE11
        end else if (hold_cnt_reg != 5'h00) begin
            hold_cnt_reg <= hold_cnt_reg - 5'h01;
            if (hold_cnt_reg == 5'h01) begin
                pins_out.sda_oe <= pend_reg; // RULE11
            end
        end
    end
    logic                aw_got_reg;
    logic                w_got_reg;
    logic [ADDR_W-1:0]   awaddr_reg;
    logic [DATA_W-1:0]   wdata_reg;
    logic [3:0]          wstrb_reg;

    wire aw_hs    = s_axi_awvalid & s_axi_awready;
    wire w_hs     = s_axi_wvalid & s_axi_wready;
    wire b_hs     = s_axi_bvalid & s_axi_bready;
    wire ar_hs    = s_axi_arvalid & s_axi_arready;
    wire r_hs     = s_axi_rvalid & s_axi_rready;
    wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire aw_got_n = aw_hs | (aw_got_reg & ~do_write);
    wire w_got_n  = w_hs | (w_got_reg & ~do_write);
    wire rvalid_n = ar_hs | (s_axi_rvalid & ~r_hs);
    wire wsel_status = awaddr_reg == ADDR_STATUS;
    wire wsel_own    = awaddr_reg == ADDR_OWN;
    wire wsel_data   = awaddr_reg == ADDR_DATA;
    wire wsel_istat  = awaddr_reg == ADDR_IRQ_STAT;
    wire wsel_mask   = awaddr_reg == ADDR_IRQ_MASK;
    wire wsel_ctrl   = awaddr_reg == ADDR_CTRL;
    wire wr_mapped   = wsel_status | wsel_own | wsel_data | wsel_istat | wsel_mask | wsel_ctrl;
    wire wr_en       = do_write & wstrb_reg[0];
    wire [7:0] wb    = wdata_reg[7:0];
    wire rsel_status = s_axi_araddr == ADDR_STATUS;
    wire rsel_own    = s_axi_araddr == ADDR_OWN;
    wire rsel_data   = s_axi_araddr == ADDR_DATA;
    wire rsel_istat  = s_axi_araddr == ADDR_IRQ_STAT;
    wire rsel_mask   = s_axi_araddr == ADDR_IRQ_MASK;
    wire rsel_ctrl   = s_axi_araddr == ADDR_CTRL;
    wire rd_mapped   = rsel_status | rsel_own | rsel_data | rsel_istat | rsel_mask | rsel_ctrl;
    wire [7:0] status_rd = {first_reg, addr_flag_reg, stop_flag_reg, rps_flag_reg,
                            txb_reg, rcb_reg, start_reg, nack_reg};
    wire [7:0] ctrl_rd   = {6'h00, xmt_reg, 1'b0};
    // own address reads as zero
    wire [7:0] rd_byte   = rsel_status ? status_rd :
                           rsel_data   ? rx_data_reg :
                           rsel_istat  ? {2'h0, irq_stat_reg} :
                           rsel_mask   ? {2'h0, irq_mask_reg} :
                           rsel_ctrl   ? ctrl_rd : 8'h00; // RULE13
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
        end else begin
            aw_got_reg    <= aw_got_n;
            w_got_reg     <= w_got_n;
            s_axi_awready <= ~aw_got_n;
            s_axi_wready  <= ~w_got_n;
            s_axi_arready <= ~rvalid_n;
            s_axi_rvalid  <= rvalid_n;
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (b_hs) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_hs) begin
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
    wire rd_data_hs  = ar_hs & rsel_data;
    wire rd_istat_hs = ar_hs & rsel_istat;
    wire clr_addr    = wr_en & wsel_status & wb[SB_ADDR];
    wire clr_stop    = wr_en & wsel_status & wb[SB_STOP];
    wire clr_rps     = wr_en & wsel_status & wb[SB_RPS];
    wire clr_nack    = got_ack | (wr_en & wsel_ctrl & wb[CTRL_NACK_CLR]);
    wire [IRQ_W-1:0] irq_evt = {got_nack, rx_done, tx_load, rps_evt, stop_det, addr_hit};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            first_reg     <= 1'b0;
            addr_flag_reg <= 1'b0;
            stop_flag_reg <= 1'b0;
            rps_flag_reg  <= 1'b0;
            txb_reg       <= 1'b0;
            rcb_reg       <= 1'b0;
            start_reg     <= 1'b0;
            nack_reg      <= 1'b0;
            rx_data_reg   <= RST_BYTE;
        end else begin
            first_reg     <= upd(first_reg, addr_hit, rx_done | mack_rise);
            addr_flag_reg <= upd(addr_flag_reg, addr_hit, clr_addr); // RULE1
            stop_flag_reg <= upd(stop_flag_reg, stop_det, clr_stop); // RULE3
            rps_flag_reg  <= upd(rps_flag_reg, rps_evt, clr_rps); // RULE4
            txb_reg       <= upd(txb_reg, tx_load, wr_en & wsel_data); // RULE5
            rcb_reg       <= upd(rcb_reg, rx_done, rd_data_hs); // RULE6
            start_reg     <= upd(start_reg, start_det, stop_det); // RULE7
            // nack only means something while transmitting
            nack_reg      <= upd(nack_reg, got_nack & xmt_reg, clr_nack); // RULE8 RULE10
            if (rx_done) begin
                rx_data_reg <= rx_in; // RULE6
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_reg     <= '0;
            own_addr_reg <= '0;
            slave_en_reg <= 1'b0;
            tx_data_reg  <= RST_BYTE;
            irq_mask_reg <= RST_IRQ;
        end else if (wr_en) begin
            if (wsel_status) begin
                hold_reg <= wb[HOLD_LSB +: HOLD_W]; // RULE11
            end
            if (wsel_own) begin
                slave_en_reg <= wb[OWN_EN_BIT]; // RULE13
                own_addr_reg <= wb[OWN_ADDR_W-1:0]; // RULE13
            end
            if (wsel_data) begin
                tx_data_reg <= wb;
            end
            if (wsel_mask) begin
                irq_mask_reg <= wb[IRQ_W-1:0];
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_stat_reg <= RST_IRQ;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= irq_evt | (irq_stat_reg & {IRQ_W{~rd_istat_hs}}); // RULE14
            irq          <= (|(irq_stat_reg & irq_mask_reg))
                            | (addr_flag_reg & irq_mask_reg[IRQ_ADDR]); // RULE2
        end
    end

endmodule

`default_nettype wire

// file: iss_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iss_slave_properties
    import iss_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [11:0]            s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire iss_pkg::iss_pins_in_t  pins_in,
    input wire iss_pkg::iss_pins_out_t pins_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic ar_hs = s_axi_arvalid && s_axi_arready;
    wire logic wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic rd_map = s_axi_araddr inside {ADDR_STATUS, ADDR_OWN, ADDR_DATA, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_CTRL};

    own_read_zero_a: assert property (ar_hs && s_axi_araddr == ADDR_OWN |=> s_axi_rdata == 32'h0)
        else $error("own address read nonzero");
    unmapped_read_a: assert property (ar_hs && !rd_map |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    read_answer_a: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    write_answer_a: assert property (wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing wrong");
    sda_pull_a: assert property ($rose(pins_out.sda_oe) |-> !pins_in.scl)
        else $error("data line pulled while clock high");
    sda_level_a: assert property (pins_out.sda_o == 1'b0)
        else $error("data line driven high");
endmodule
bind iss_slave iss_slave_properties i_iss_slave_properties (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .pins_out);
`default_nettype wire

// file: iss_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module iss_master_model #(
    parameter int HALF = 400
) (
    output logic     scl,
    output logic     sda_low,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // low phase stretched: the slave moves sda up to hold+8 cycles after the fall
    task automatic clk_bit(input logic b, output logic s);
        #(HALF / 16) sda_low = !b;
        #(2 * HALF) scl = 1'b1;
        #(HALF / 2) s = sda_line;
        #(HALF / 2) scl = 1'b0;
        #HALF;
    endtask
    task automatic start();
        #(HALF / 16) sda_low = 1'b0;
        #(2 * HALF) scl = 1'b1;
        #HALF sda_low = 1'b1;
        #HALF scl = 1'b0;
        #HALF;
    endtask
    task automatic stop();
        #(HALF / 16) sda_low = 1'b1;
        #(2 * HALF) scl = 1'b1;
        #HALF sda_low = 1'b0;
        #HALF;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(nack, s);
    endtask
endmodule
`default_nettype wire

// file: iss_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module iss_slave_tb_top;
    import iss_pkg::*;
    logic          sys_clk = 1'b0, rst = 1'b1;
    logic [11:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]   s_axi_wdata = '0, s_axi_rdata, v;
    logic [3:0]    s_axi_wstrb = 4'hf, hold;
    logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    iss_pins_in_t  pins_in;
    iss_pins_out_t pins_out;
    logic          m_scl, m_low, sda_line, ack, scl_q, oe_q;
    logic [6:0]    own;
    logic [7:0]    rx, t1, t2, b;
    int            n_mismatch = 0, tests_run = 0, hold_cnt = 0, oe_delay = 0;

    always #50 sys_clk = ~sys_clk;
    iss_slave i_iss_slave (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in,
        .pins_out, .irq);
    iss_master_model mm (.scl(m_scl), .sda_low(m_low), .sda_line(sda_line));
    assign sda_line = !(m_low || pins_out.sda_oe);
    assign pins_in = '{scl: m_scl, sda: sda_line};

    // cycles from pin scl fall to sda pull
    always @(posedge sys_clk) begin
        scl_q <= m_scl;
        oe_q <= pins_out.sda_oe;
        hold_cnt <= (scl_q && !m_scl) ? 0 : hold_cnt + 1;
        if (!oe_q && pins_out.sda_oe) oe_delay <= hold_cnt;
    end

    function automatic logic [31:0] hold_ok(int d, logic [3:0] h);
        return 32'(d >= int'(h) + 3 && d <= int'(h) + 9);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n, dly;
        dly = $urandom % 3;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= (n >= dly);
        end
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            n_mismatch++;
            complete_run();
        end
        check(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        int n, dly;
        dly = $urandom % 3;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= (n >= dly);
        end
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            n_mismatch++;
            complete_run();
        end
        d = s_axi_rdata;
        check(32'(s_axi_rresp), 32'(er));
    endtask
    task automatic chk_st(input logic [7:0] m, input logic [7:0] e);
        logic [31:0] s;
        axi_rd(ADDR_STATUS, s, RESP_OKAY);
        check(s & 32'(m), 32'(e));
    endtask

    initial begin
        void'($urandom(93));
        own = 7'($urandom);
        hold = 4'($urandom % 5);
        rx = 8'($urandom);
        t1 = 8'($urandom);
        t2 = 8'($urandom);
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        chk_st(8'hff, 8'h00);
        axi_rd(ADDR_OWN, v, RESP_OKAY);
        check(v, 32'h0);
        axi_rd(ADDR_IRQ_MASK, v, RESP_OKAY);
        check(v, 32'h0);
        axi_rd(12'hffc, v, RESP_SLVERR);
        axi_wr(12'hffc, 32'h0, RESP_SLVERR);
        $display("reset and map test done");
        axi_wr(ADDR_OWN, {24'h0, 1'b1, own}, RESP_OKAY);
        axi_wr(ADDR_STATUS, {28'h0, hold}, RESP_OKAY);
        mm.start();
        mm.wbyte({own, 1'b0}, ack);
        check(32'(ack), 32'h0);
        check(hold_ok(oe_delay, hold), 32'h1);
        chk_st(8'hc2, 8'hc2);
        check(32'(irq), 32'h0);
        mm.wbyte(rx, ack);
        chk_st(8'h84, 8'h04);
        axi_rd(ADDR_DATA, v, RESP_OKAY);
        check(v, {24'h0, rx});
        chk_st(8'h04, 8'h00);
        mm.start();
        mm.wbyte({own ^ 7'h01, 1'b0}, ack);
        check(32'(ack), 32'h1);
        chk_st(8'h10, 8'h10);
        mm.stop();
        chk_st(8'h22, 8'h20);
        axi_wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        axi_wr(ADDR_STATUS, {24'h0, 4'h7, hold}, RESP_OKAY);
        chk_st(8'h70, 8'h00);
        axi_rd(ADDR_IRQ_STAT, v, RESP_OKAY);
        check(v & 32'h1, 32'h1);
        repeat (2) @(posedge sys_clk);
        check(32'(irq), 32'h0);
        $display("write transfer test done");
        axi_wr(ADDR_DATA, {24'h0, t1}, RESP_OKAY);
        mm.start();
        mm.wbyte({own, 1'b1}, ack);
        check(32'(ack), 32'h0);
        mm.rbyte(1'b1, b);
        check(32'(b), 32'(t1));
        chk_st(8'h09, 8'h09);
        mm.stop();
        axi_wr(ADDR_DATA, {24'h0, t2}, RESP_OKAY);
        chk_st(8'h08, 8'h00);
        mm.start();
        mm.wbyte({own, 1'b1}, ack);
        mm.rbyte(1'b0, b);
        check(32'(b), 32'(t1));
        chk_st(8'h01, 8'h00);
        mm.rbyte(1'b1, b);
        check(32'(b), 32'(t2));
        mm.stop();
        chk_st(8'h01, 8'h01);
        axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        chk_st(8'h01, 8'h00);
        $display("read transfer test done");
        complete_run();
    end
endmodule
`default_nettype wire
